// [core/pwc_cfg.svh]
// register offsets, field positions and count and edge-select values of the capture timer
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PWC_OFF_MODE 8'h00
`define PWC_OFF_CAPCTL 8'h04
`define PWC_OFF_PRESC 8'h08
`define PWC_OFF_COUNT 8'h0C
`define PWC_OFF_CAPA 8'h10
`define PWC_OFF_CAPB 8'h14
`define PWC_OFF_ISTAT 8'h18
`define PWC_OFF_IMASK 8'h1C
`define PWC_OFF_OUTCTL 8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PWC_MODE_OVF 0
`define PWC_MODE_OP_LO 2
`define PWC_MODE_OP_HI 3
`define PWC_CAP_A_EN 0
`define PWC_CAP_A_REV 1
`define PWC_CAP_B_EN 2
`define PWC_PRE_CLK_LO 0
`define PWC_PRE_CLK_HI 1
`define PWC_PRE_ESA_LO 4
`define PWC_PRE_ESA_HI 5
`define PWC_PRE_ESB_LO 6
`define PWC_PRE_ESB_HI 7
`define PWC_IRQ_A 0
`define PWC_IRQ_B 1
`define PWC_IRQ_OVF 2

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define PWC_CNT_MAX 16'hFFFF
`define PWC_CNT_ZERO 16'h0000
`define PWC_ES_FALL 2'h0
`define PWC_ES_RISE 2'h1
`define PWC_ES_BOTH 2'h3

`endif

// [core/pwc_pkg.sv]
// types shared by the pulse width capture timer
package pwc_pkg;

    typedef enum logic [1:0] {
        OP_STOP = 2'b00,
        OP_FREE = 2'b01,
        OP_CLEAR_A = 2'b10,
        OP_CLEAR_MATCH = 2'b11
    } op_mode_t;

    typedef struct packed {
        logic [15:0] main_counter;
        logic [15:0] capture_reg_a;
        logic [15:0] capture_reg_b;
        op_mode_t op_mode;
        logic overflow_flag;
        logic [2:0] capture_compare_ctrl_reg;
        logic [7:0] prescaler_mode_reg;
        logic [7:0] timer_output_control;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [7:0] div;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic irq;
        logic capture_irq_a;
        logic capture_irq_b;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage : pwc_pkg

// [core/pulse_width_capture_timer.sv]
// 16-bit pulse width capture timer with apb registers
//
// Function
// - free-running: input a valid edge loads reg b, input b edge loads reg a.
// - single input: opposite edge of input a loads reg a, valid edge reg b.
// - clear-and-start: valid edge of a loads reg b, clears counter; opposite loads a.
// - clear-and-start without overflow: reg b holds the input period less one count.
// - overflow flag set on overflow; software clears it by writing zero.
// - reg a trigger selectable between input a opposite edge and input b.
// - reg b always triggered by input a valid edge, stores current count.
// - reg a capture on opposite phase of input a raises no reg a interrupt.
// - every reg b capture raises the reg b capture interrupt.
// - reading the counter returns the count and does not disturb counting.
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pulse_width_capture_timer #(
    parameter int DIV_SEL1 = 4,
    parameter int DIV_SEL2 = 16,
    parameter int DIV_SEL3 = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    output logic capture_irq_a,
    output logic capture_irq_b,
    output logic irq
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    generate
        if (DIV_SEL1 < 1 || DIV_SEL1 > 256 || DIV_SEL2 < 1 || DIV_SEL2 > 256 ||
            DIV_SEL3 < 1 || DIV_SEL3 > 256) begin : g_bad_div
            $error("prescaler divisors must lie in 1..256");
        end
    endgenerate

    // ------------------------------------------------------------------
    // edge helpers
    // ------------------------------------------------------------------
    function automatic logic valid_edge(input logic [1:0] es, input logic r,
                                        input logic f);
        valid_edge = 1'b0;
        if (es == `PWC_ES_FALL) valid_edge = f;
        else if (es == `PWC_ES_RISE) valid_edge = r;
        else if (es == `PWC_ES_BOTH) valid_edge = r | f;
    endfunction : valid_edge

    // opposite phase only exists for a single-edge selection
    function automatic logic opp_edge(input logic [1:0] es, input logic r,
                                      input logic f);
        opp_edge = 1'b0;
        if (es == `PWC_ES_FALL) opp_edge = r;
        else if (es == `PWC_ES_RISE) opp_edge = f;
    endfunction : opp_edge

    // ------------------------------------------------------------------
    // state and combinational next value
    // ------------------------------------------------------------------
    pwc_pkg::state_t q;
    pwc_pkg::state_t d;

    logic a_valid;
    logic a_opp;
    logic b_valid;
    logic running;
    logic tick;
    logic wrap;
    logic cap_a_ev;
    logic cap_b_ev;
    logic irq_a_ev;
    logic setup;
    logic wr;
    logic rd;
    logic [7:0] div_lim;

    always_comb begin
        d = q;
        d.sync_a = {q.sync_a[1], q.sync_a[0], capture_input_a};
        d.sync_b = {q.sync_b[1], q.sync_b[0], capture_input_b};
        a_valid = valid_edge(q.prescaler_mode_reg[`PWC_PRE_ESA_HI:`PWC_PRE_ESA_LO],
                             q.sync_a[1] & ~q.sync_a[2], ~q.sync_a[1] & q.sync_a[2]);
        a_opp = opp_edge(q.prescaler_mode_reg[`PWC_PRE_ESA_HI:`PWC_PRE_ESA_LO],
                         q.sync_a[1] & ~q.sync_a[2], ~q.sync_a[1] & q.sync_a[2]);
        b_valid = valid_edge(q.prescaler_mode_reg[`PWC_PRE_ESB_HI:`PWC_PRE_ESB_LO],
                             q.sync_b[1] & ~q.sync_b[2], ~q.sync_b[1] & q.sync_b[2]);
        running = (q.op_mode != pwc_pkg::OP_STOP);

        // count clock: pclk or one of three internal divided rates
        unique case (q.prescaler_mode_reg[`PWC_PRE_CLK_HI:`PWC_PRE_CLK_LO])
            2'h0: div_lim = 8'h00;
            2'h1: div_lim = 8'(DIV_SEL1 - 1);
            2'h2: div_lim = 8'(DIV_SEL2 - 1);
            2'h3: div_lim = 8'(DIV_SEL3 - 1);
        endcase
        tick = 1'b0;
        if (!running) begin
            d.div = 8'h00;
        end else if (q.div >= div_lim) begin
            d.div = 8'h00;
            tick = 1'b1;
        end else begin
            d.div = q.div + 8'h01;
        end

        // counter
        wrap = 1'b0;
        if (!running) begin
            d.main_counter = `PWC_CNT_ZERO;
        end else if (q.op_mode == pwc_pkg::OP_CLEAR_A && a_valid) begin
            d.main_counter = `PWC_CNT_ZERO;
        end else if (tick) begin
            d.main_counter = q.main_counter + 16'h0001;
            wrap = (q.main_counter == `PWC_CNT_MAX);
        end

        // captures
        cap_b_ev = running & q.capture_compare_ctrl_reg[`PWC_CAP_B_EN] & a_valid;
        cap_a_ev = running & q.capture_compare_ctrl_reg[`PWC_CAP_A_EN] &
                   (q.capture_compare_ctrl_reg[`PWC_CAP_A_REV] ? a_opp : b_valid);
        irq_a_ev = cap_a_ev & ~q.capture_compare_ctrl_reg[`PWC_CAP_A_REV];
        if (cap_b_ev) d.capture_reg_b = q.main_counter;
        if (cap_a_ev) d.capture_reg_a = q.main_counter;
        d.capture_irq_a = irq_a_ev;
        d.capture_irq_b = cap_b_ev;

        // apb: one wait-free access phase, answer prepared in setup
        setup = psel & ~penable;
        wr = psel & penable & q.pready & pwrite;
        rd = psel & penable & q.pready & ~pwrite;
        d.pready = setup;
        d.pslverr = 1'b0;
        d.prdata = 32'h0000_0000;
        if (setup) begin
            unique case (paddr)
                `PWC_OFF_MODE: d.prdata = {28'h0, q.op_mode, 1'b0, q.overflow_flag};
                `PWC_OFF_CAPCTL: d.prdata = {29'h0, q.capture_compare_ctrl_reg};
                `PWC_OFF_PRESC: d.prdata = {24'h0, q.prescaler_mode_reg};
                `PWC_OFF_COUNT: d.prdata = {16'h0, q.main_counter};
                `PWC_OFF_CAPA: d.prdata = {16'h0, q.capture_reg_a};
                `PWC_OFF_CAPB: d.prdata = {16'h0, q.capture_reg_b};
                `PWC_OFF_ISTAT: d.prdata = {29'h0, q.irq_stat};
                `PWC_OFF_IMASK: d.prdata = {29'h0, q.irq_mask};
                `PWC_OFF_OUTCTL: d.prdata = {24'h0, q.timer_output_control};
                default: d.pslverr = 1'b1;
            endcase
        end else if (q.pready) begin
            d.prdata = q.prdata;
        end

        if (wr) begin
            unique case (paddr)
                `PWC_OFF_MODE: begin
                    d.op_mode = pwc_pkg::op_mode_t'(pwdata[`PWC_MODE_OP_HI:`PWC_MODE_OP_LO]);
                    d.overflow_flag = q.overflow_flag & pwdata[`PWC_MODE_OVF];
                end
                `PWC_OFF_CAPCTL: d.capture_compare_ctrl_reg = pwdata[2:0];
                `PWC_OFF_PRESC: d.prescaler_mode_reg = pwdata[7:0];
                `PWC_OFF_IMASK: d.irq_mask = pwdata[2:0];
                `PWC_OFF_OUTCTL: d.timer_output_control = pwdata[7:0];
                default: d.op_mode = q.op_mode;
            endcase
        end
        // only the bits that were shown are cleared, so a late event survives
        if (rd && paddr == `PWC_OFF_ISTAT) d.irq_stat = q.irq_stat & ~q.prdata[2:0];

        // hardware sets win over software clears
        if (wrap) d.overflow_flag = 1'b1;
        d.irq_stat[`PWC_IRQ_A] = d.irq_stat[`PWC_IRQ_A] | irq_a_ev;
        d.irq_stat[`PWC_IRQ_B] = d.irq_stat[`PWC_IRQ_B] | cap_b_ev;
        d.irq_stat[`PWC_IRQ_OVF] = d.irq_stat[`PWC_IRQ_OVF] | wrap;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= pwc_pkg::state_t'('0);
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign capture_irq_a = q.capture_irq_a;
    assign capture_irq_b = q.capture_irq_b;
    assign irq = q.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_clear_edge;
        q.op_mode == pwc_pkg::OP_CLEAR_A && a_valid;
    endsequence

    sequence s_wrap_tick;
        running && tick && q.main_counter == `PWC_CNT_MAX && !a_valid;
    endsequence

    a_free_two_input: assert property (@(posedge pclk) disable iff (!presetn)
        (q.op_mode == pwc_pkg::OP_FREE && q.capture_compare_ctrl_reg == 3'h5 && b_valid)
        |=> q.capture_reg_a == $past(q.main_counter) && q.capture_irq_a)
        else $error("reg a missed input b capture");

    a_rev_phase_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (running && q.capture_compare_ctrl_reg == 3'h7 && a_opp)
        |=> q.capture_reg_a == $past(q.main_counter))
        else $error("reg a missed opposite edge capture");

    a_rev_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (q.capture_compare_ctrl_reg[`PWC_CAP_A_REV] && cap_a_ev) |=> !q.capture_irq_a)
        else $error("reg a interrupt on opposite phase capture");

    a_clear_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_edge |=> q.main_counter == `PWC_CNT_ZERO)
        else $error("counter not cleared on valid edge");

    a_period_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (s_clear_edge and q.capture_compare_ctrl_reg[`PWC_CAP_B_EN])
        |=> q.capture_reg_b == $past(q.main_counter) && q.main_counter == `PWC_CNT_ZERO)
        else $error("period not captured in reg b");

    a_cap_b_value: assert property (@(posedge pclk) disable iff (!presetn)
        cap_b_ev |=> q.capture_reg_b == $past(q.main_counter))
        else $error("reg b holds wrong count");

    a_cap_b_irq: assert property (@(posedge pclk) disable iff (!presetn)
        cap_b_ev |=> q.capture_irq_b ##1 !q.capture_irq_b || $past(cap_b_ev))
        else $error("reg b interrupt missing");

    a_wrap_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        s_wrap_tick |=> q.overflow_flag && q.main_counter == `PWC_CNT_ZERO &&
        q.irq_stat[`PWC_IRQ_OVF])
        else $error("wrap did not set overflow");

    a_cap_a_select: assert property (@(posedge pclk) disable iff (!presetn)
        (running && q.capture_compare_ctrl_reg == 3'h1 && a_valid && !b_valid)
        |=> $stable(q.capture_reg_a))
        else $error("reg a captured on wrong input");

    a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == `PWC_OFF_COUNT && !pwrite && running && !a_valid)
        |=> q.prdata[15:0] == $past(q.main_counter) && q.main_counter == $past(d.main_counter))
        else $error("counter read wrong or disturbed");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        q.irq == |(q.irq_stat & q.irq_mask))
        else $error("interrupt level mismatch");

endmodule : pulse_width_capture_timer

// [bench/pwc_pulse_src.sv]
// external pulse source driving both capture pins
`timescale 1ns/1ps

module pwc_pulse_src (
    input wire logic pclk,
    input wire logic run,
    input wire logic [15:0] period,
    input wire logic [15:0] high,
    input wire logic [15:0] lag,
    output logic pin_a = 1'b0,
    output logic pin_b = 1'b0
);
    // ------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------
    logic [15:0] ph = 16'h0000;
    logic [15:0] ph_b;

    assign ph_b = (ph >= lag) ? ph - lag : ph + period - lag;

    // pins idle low between bursts, edges land just after a clock edge
    always @(posedge pclk) begin
        if (!run) begin
            ph <= 16'h0000;
            pin_a <= 1'b0;
            pin_b <= 1'b0;
        end else begin
            ph <= (ph == period - 16'h0001) ? 16'h0000 : ph + 16'h0001;
            pin_a <= ph < high;
            pin_b <= ph_b < high;
        end
    end
endmodule : pwc_pulse_src

// [bench/pulse_width_capture_timer_tb.sv]
// self-checking bench of the pulse width capture timer
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pulse_width_capture_timer_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, cap_a, cap_b, capture_irq_a, capture_irq_b, irq;
    logic run = 1'b0;
    logic [15:0] per = 16'h0030;
    logic [15:0] hi = 16'h0010;
    logic [15:0] lag = 16'h0000;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int na = 0;
    int stamp;
    int seed = 32'h33E726CA;
    int divs [4] = '{1, 2, 3, 5};
    logic [31:0] rd;

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (capture_irq_a === 1'b1) begin
            na <= na + 1;
        end
    end

    // small dividers keep prescaled runs short
    pulse_width_capture_timer #(.DIV_SEL1(2), .DIV_SEL2(3), .DIV_SEL3(5))
    i_pulse_width_capture_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_a(cap_a), .capture_input_b(cap_b),
        .capture_irq_a(capture_irq_a), .capture_irq_b(capture_irq_b), .irq(irq));

    pwc_pulse_src i_pwc_pulse_src (.pclk(pclk), .run(run), .period(per),
        .high(hi), .lag(lag), .pin_a(cap_a), .pin_b(cap_b));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // bounded wait for pready; read data taken at that edge only
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, 32'(pready));
        rd = pslverr ? 32'hDEAD0000 : prdata;
        stamp = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(input logic sel_a);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((sel_a ? capture_irq_a : capture_irq_b) !== 1'b1 && n < 3000);
        chk("capture irq", 32'h1, 32'(sel_a ? capture_irq_a : capture_irq_b));
    endtask : wait_irq

    task automatic start(input int p, input int h, input int l);
        @(posedge pclk);
        per <= p[15:0];
        hi <= h[15:0];
        lag <= l[15:0];
        run <= 1'b1;
    endtask : start

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (95000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int p, h, l, k, w, t0;
        logic [15:0] a16, b16, bp;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PWC_OFF_MODE, 0);
        chk("mode reset", 32'h0, rd);
        apb(0, 8'h24, 0);
        chk("unmapped", 32'hDEAD0000, rd);
        apb(1, `PWC_OFF_OUTCTL, 32'h5A);
        apb(0, `PWC_OFF_OUTCTL, 0);
        chk("outctl", 32'h5A, rd);
        apb(1, `PWC_OFF_MODE, 32'h04);
        apb(0, `PWC_OFF_COUNT, 0);
        t0 = stamp - int'(rd);
        apb(0, `PWC_OFF_COUNT, 0);
        chk("count run", 32'(stamp - t0), rd);
        $display("test registers done");
        // single input: free/clear, valid fall/rise; opposite-phase reg a capture raises no irq a, irq masked off
        for (int m = 0; m < 4; m++) begin
            p = 50 + $unsigned($random(seed)) % 60;
            h = 20 + $unsigned($random(seed)) % (p - 40);
            w = m[0] ? p - h : h;
            apb(1, `PWC_OFF_MODE, 0);
            apb(1, `PWC_OFF_IMASK, 0);
            apb(1, `PWC_OFF_PRESC, m[0] ? 32'h10 : 32'h00);
            apb(1, `PWC_OFF_CAPCTL, 32'h07);
            apb(1, `PWC_OFF_MODE, m[1] ? 32'h08 : 32'h04);
            start(p, h, 0);
            k = na;
            wait_irq(0);
            apb(0, `PWC_OFF_CAPB, 0);
            bp = rd[15:0];
            repeat (3) begin
                wait_irq(0);
                apb(0, `PWC_OFF_CAPB, 0);
                b16 = rd[15:0];
                apb(0, `PWC_OFF_CAPA, 0);
                a16 = rd[15:0];
                if (m[1]) begin
                    chk("clear period", 32'(p - 1), {16'h0, b16});
                    chk("clear high", 32'(p - w - 1), {16'h0, a16});
                end else begin
                    chk("free width", 32'(w), {16'h0, 16'(b16 - a16)});
                    chk("free period", 32'(p), {16'h0, 16'(b16 - bp)});
                end
                bp = b16;
            end
            chk("no irq a", 32'(k), 32'(na));
            chk("masked irq", 32'h0, 32'(irq));
            apb(1, `PWC_OFF_MODE, 0);
            run <= 1'b0;
            apb(0, `PWC_OFF_ISTAT, 0);
            chk("status", 32'h2, rd);
            apb(0, `PWC_OFF_ISTAT, 0);
            chk("status cleared", 32'h0, rd);
            $display("test single input done");
        end
        // two inputs, both edges, random count clock
        repeat (3) begin
            k = $unsigned($random(seed)) % 4;
            p = 50 + $unsigned($random(seed)) % 40;
            h = 20 + $unsigned($random(seed)) % (p - 40);
            l = 2 + $unsigned($random(seed)) % 4;
            apb(1, `PWC_OFF_IMASK, 32'h3);
            apb(1, `PWC_OFF_PRESC, 32'hF0 | k);
            apb(1, `PWC_OFF_CAPCTL, 32'h05);
            apb(1, `PWC_OFF_MODE, 32'h04);
            start(p * divs[k], h * divs[k], l * divs[k]);
            wait_irq(1);
            repeat (3) begin
                wait_irq(1);
                apb(0, `PWC_OFF_CAPB, 0);
                b16 = rd[15:0];
                apb(0, `PWC_OFF_CAPA, 0);
                a16 = rd[15:0];
                chk("two input", 32'(l), {16'h0, 16'(a16 - b16)});
            end
            chk("irq level", 32'h1, 32'(irq));
            apb(1, `PWC_OFF_MODE, 0);
            run <= 1'b0;
            apb(0, `PWC_OFF_ISTAT, 0);
            chk("status", 32'h3, rd);
            repeat (2) @(posedge pclk);
            chk("irq low", 32'h0, 32'(irq));
            $display("test two input done");
        end
        // overflow after one full wrap, clear-and-start with pins idle
        apb(1, `PWC_OFF_IMASK, 32'h4);
        apb(1, `PWC_OFF_PRESC, 0);
        apb(1, `PWC_OFF_MODE, 32'h08);
        t0 = stamp;
        repeat (65600) @(posedge pclk);
        apb(0, `PWC_OFF_MODE, 0);
        chk("overflow flag", 32'h9, rd);
        chk("ovf irq", 32'h1, 32'(irq));
        apb(0, `PWC_OFF_COUNT, 0);
        chk("wrapped", 32'h1, 32'(rd < 32'h100));
        // counter is zero at the edge the mode write lands; read data is the count from two edges before the access edge
        chk("ovf span", 32'(stamp - t0 - 2), 32'h10000 + rd);
        apb(1, `PWC_OFF_MODE, 32'h08);
        apb(0, `PWC_OFF_MODE, 0);
        chk("flag cleared", 32'h8, rd);
        apb(0, `PWC_OFF_ISTAT, 0);
        chk("ovf status", 32'h4, rd);
        $display("test overflow done");
        tally_and_finish();
    end
endmodule : pulse_width_capture_timer_tb
